// *** verilog/acs_map.vh ***
// Purpose: Offsets, field positions, reset values and timing counts of the sequencer
// Assumes: 16-bit register port, word offsets
// Notes:   Included by the sequencer; the result store does not include it
`ifndef ACS_MAP_VH
`define ACS_MAP_VH
`define ACS_OFF_CTRL1      4'h0
`define ACS_OFF_RESULT     4'h1
`define ACS_OFF_IRQ_STAT   4'h2
`define ACS_OFF_IRQ_EN     4'h3
`define ACS_OFF_IRQ_CLR    4'h4
`define ACS_OFF_RES_IDX    4'h5
`define ACS_BIT_ON         15
`define ACS_BIT_IDLE_STOP  13
`define ACS_BIT_OUTPUT_FORMAT_HI    9
`define ACS_BIT_OUTPUT_FORMAT_LO    8
`define ACS_BIT_TRIG_HI    7
`define ACS_BIT_TRIG_LO    5
`define ACS_BIT_AUTO       2
`define ACS_BIT_SAMPLE     1
`define ACS_BIT_DONE       0
`define ACS_CTRL1_WMASK    16'hA3E7
`define ACS_CTRL1_RESET    16'h0000
`define ACS_TRIG_MANUAL    3'h0
`define ACS_TRIG_EXT_PIN   3'h1
`define ACS_TRIG_TIMER_A   3'h2
`define ACS_TRIG_TIMER_B   3'h4
`define ACS_TRIG_CHARGE    3'h6
`define ACS_TRIG_AUTO      3'h7
`define ACS_OUTPUT_FORMAT_INT       2'h0
`define ACS_OUTPUT_FORMAT_SINT      2'h1
`define ACS_OUTPUT_FORMAT_FRAC      2'h2
`define ACS_OUTPUT_FORMAT_SFRAC     2'h3
`define ACS_AUTO_CONV_CYC  8'h0F
`define ACS_IRQ_DONE       0
`define ACS_IRQ_TRIG       1
`define ACS_IRQ_ERR        2
`endif

// *** verilog/acs_result_mem.v ***
// Purpose: Result store of the sequencer, cleared while the converter is off
// Assumes: One write port, one registered read port
// Notes:   Contents are dropped when the converter is turned off
`timescale 1ns/1ps
module acs_result_mem #(
    parameter DEPTH = 16,
    parameter AW    = 4,
    parameter DW    = 10
) (
    // Clock and reset
    input  wire          sys_clk,
    input  wire          rst,
    input  wire          clr,
    // Write side
    input  wire          wr_en,
    input  wire [AW-1:0] wr_addr,
    input  wire [DW-1:0] wr_data,
    // Read side
    input  wire [AW-1:0] rd_addr,
    output reg  [DW-1:0] rd_data
);
    reg [DW-1:0] mem [0:DEPTH-1];
    genvar g;
    generate
        for (g = 0; g < DEPTH; g = g + 1) begin : gen_word
            always @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    mem[g] <= {DW{1'b0}};
                end else if (clr) begin
                    mem[g] <= {DW{1'b0}};
                end else if (wr_en && wr_addr == g) begin
                    mem[g] <= wr_data;
                end
            end
        end
    endgenerate
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rd_data <= {DW{1'b0}};
        end else begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

// *** verilog/acs_seq.v ***
// Purpose: Control register and sample/convert sequencer of a SAR converter
// Assumes: Trigger and analog-core status inputs are asynchronous and get two flops
// Notes:   Register port is word addressed; read data stand one cycle after the strobe
`timescale 1ns/1ps
`include "acs_map.vh"
module acs_seq #(
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    // Clock and reset
    input  wire        sys_clk,
    input  wire        rst,
    // Register port
    input  wire [3:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [15:0] reg_rdata,
    // Trigger sources
    input  wire        trig_charge,
    input  wire        trig_timer_a,
    input  wire        trig_timer_b,
    input  wire        ext_int_pin,
    // Device mode
    input  wire        cpu_idle,
    // Analog core
    output reg         sh_sample,
    output reg         conv_start,
    input  wire        conv_busy,
    input  wire [9:0]  conv_result,
    // Interrupt
    output wire        irq
);
    localparam ST_OFF    = 2'h0;
    localparam ST_HOLD   = 2'h1;
    localparam ST_SAMPLE = 2'h2;
    localparam ST_CONV   = 2'h3;

    reg  [15:0]   ctrl_r;
    reg  [1:0]    state_r;
    reg  [2:0]    irq_stat_r;
    reg  [2:0]    irq_en_r;
    reg  [AW-1:0] wr_idx_r;
    reg  [AW-1:0] rd_idx_r;
    reg  [7:0]    auto_cnt_r;
    reg           rd_pend_r;
    reg  [3:0]    rd_addr_r;
    reg  [1:0]    tc_s1_r;
    reg  [1:0]    tc_s2_r;
    reg  [1:0]    tt_s1_r;
    reg  [1:0]    tt_s2_r;
    reg  [1:0]    busy_s_r;
    reg  [9:0]    res_s1_r;
    reg  [9:0]    res_s2_r;
    reg  [4:0]    trig_prev_r;
    wire [9:0]    mem_rdata;
    wire [4:0]    trig_now;
    wire [4:0]    trig_edge;
    wire          conv_end;
    wire          on;
    wire          run;
    wire [2:0]    tsel;
    reg           trig_hit;
    reg           trig_bad;

    // Pulls one field out of the control word
    function [2:0] tsel_of;
        input [15:0] c;
        begin
            tsel_of = c[`ACS_BIT_TRIG_HI:`ACS_BIT_TRIG_LO];
        end
    endfunction

    // Applies the output format to a 10-bit result
    function [15:0] fmt;
        input [1:0] f;
        input [9:0] d;
        begin
            case (f)
                `ACS_OUTPUT_FORMAT_INT:  fmt = {6'h00, d};
                `ACS_OUTPUT_FORMAT_SINT: fmt = {{7{~d[9]}}, d[8:0]};
                `ACS_OUTPUT_FORMAT_FRAC: fmt = {d, 6'h00};
                default:        fmt = {~d[9], d[8:0], 6'h00};
            endcase
        end
    endfunction

    assign on   = ctrl_r[`ACS_BIT_ON];
    assign run  = on && !(cpu_idle && ctrl_r[`ACS_BIT_IDLE_STOP]);
    assign tsel = tsel_of(ctrl_r);

    // Two-flop synchronisers for the trigger and analog-core inputs; cpu_idle is used unsynchronised
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tc_s1_r  <= 2'h0;
            tc_s2_r  <= 2'h0;
            tt_s1_r  <= 2'h0;
            tt_s2_r  <= 2'h0;
            busy_s_r <= 2'h0;
            res_s1_r <= 10'h000;
            res_s2_r <= 10'h000;
        end else begin
            tc_s1_r  <= {trig_charge, ext_int_pin};
            tc_s2_r  <= tc_s1_r;
            tt_s1_r  <= {trig_timer_b, trig_timer_a};
            tt_s2_r  <= tt_s1_r;
            busy_s_r <= {busy_s_r[0], conv_busy};
            res_s1_r <= conv_result;
            res_s2_r <= res_s1_r;
        end
    end

    assign trig_now  = {tc_s2_r[1], tt_s2_r[1], tt_s2_r[0], tc_s2_r[0], busy_s_r[1]};
    assign trig_edge = trig_now & ~trig_prev_r;
    assign conv_end  = trig_prev_r[0] & ~busy_s_r[1];

    always @* begin
        trig_hit = 1'b0;
        trig_bad = 1'b0;
        case (tsel)
            `ACS_TRIG_EXT_PIN: trig_hit = trig_edge[1];
            `ACS_TRIG_TIMER_A: trig_hit = trig_edge[2];
            `ACS_TRIG_TIMER_B: trig_hit = trig_edge[3];
            `ACS_TRIG_CHARGE:  trig_hit = trig_edge[4];
            `ACS_TRIG_AUTO:    trig_hit = (auto_cnt_r == `ACS_AUTO_CONV_CYC);
            `ACS_TRIG_MANUAL:  trig_hit = 1'b0;
            default:           trig_bad = 1'b1;
        endcase
    end

    wire ctrl_wr   = reg_wr && reg_addr == `ACS_OFF_CTRL1;
    wire sw_sample = ctrl_wr && reg_wdata[`ACS_BIT_SAMPLE];
    wire sw_hold   = ctrl_wr && !reg_wdata[`ACS_BIT_SAMPLE] && ctrl_r[`ACS_BIT_SAMPLE];
    wire go_conv   = run && state_r == ST_SAMPLE &&
                     (trig_hit || (tsel == `ACS_TRIG_MANUAL && sw_hold));
    wire done_ev   = state_r == ST_CONV && conv_end;

    // Sequencer and control register
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl_r      <= `ACS_CTRL1_RESET;
            state_r     <= ST_OFF;
            trig_prev_r <= 5'h00;
            auto_cnt_r  <= 8'h00;
            conv_start  <= 1'b0;
            sh_sample   <= 1'b0;
            wr_idx_r    <= {AW{1'b0}};
        end else begin
            trig_prev_r <= trig_now;
            conv_start  <= 1'b0;
            if (ctrl_wr) begin
                ctrl_r <= (ctrl_r & ~`ACS_CTRL1_WMASK) | (reg_wdata & `ACS_CTRL1_WMASK);
            end
            if (state_r == ST_SAMPLE && tsel == `ACS_TRIG_AUTO) begin
                auto_cnt_r <= auto_cnt_r + 8'h01;
            end else begin
                auto_cnt_r <= 8'h00;
            end
            case (state_r)
                ST_OFF: begin
                    sh_sample <= 1'b0;
                    if (run) begin
                        state_r <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (sw_sample) begin
                        state_r   <= ST_SAMPLE;
                        sh_sample <= 1'b1;
                    end
                end
                ST_SAMPLE: begin
                    if (go_conv) begin
                        state_r    <= ST_CONV;
                        sh_sample  <= 1'b0;
                        conv_start <= 1'b1;
                        ctrl_r[`ACS_BIT_SAMPLE] <= 1'b0;
                        ctrl_r[`ACS_BIT_DONE]   <= 1'b0;
                    end
                end
                ST_CONV: begin
                    if (done_ev) begin
                        ctrl_r[`ACS_BIT_DONE] <= 1'b1;
                        wr_idx_r <= wr_idx_r + {{(AW-1){1'b0}}, 1'b1};
                        if (ctrl_r[`ACS_BIT_AUTO]) begin
                            state_r   <= ST_SAMPLE;
                            sh_sample <= 1'b1;
                            ctrl_r[`ACS_BIT_SAMPLE] <= 1'b1;
                        end else begin
                            state_r <= ST_HOLD;
                        end
                    end
                end
                default: state_r <= ST_OFF;
            endcase
            if (!run) begin
                state_r   <= ST_OFF;
                sh_sample <= 1'b0;
            end
            if (!on) begin
                wr_idx_r <= {AW{1'b0}};
            end
        end
    end

    acs_result_mem #(
        .DEPTH (DEPTH),
        .AW    (AW),
        .DW    (10)
    ) u_mem (
        .sys_clk (sys_clk),
        .rst     (rst),
        .clr     (!on),
        .wr_en   (done_ev),
        .wr_addr (wr_idx_r),
        .wr_data (res_s2_r),
        .rd_addr (rd_idx_r),
        .rd_data (mem_rdata)
    );

    // Interrupt status, enable, write-one clear; set wins
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_stat_r <= 3'h0;
            irq_en_r   <= 3'h0;
            rd_idx_r   <= {AW{1'b0}};
        end else begin
            if (reg_wr && reg_addr == `ACS_OFF_IRQ_EN) begin
                irq_en_r <= reg_wdata[2:0];
            end
            if (reg_wr && reg_addr == `ACS_OFF_RES_IDX) begin
                rd_idx_r <= reg_wdata[AW-1:0];
            end
            irq_stat_r <= (irq_stat_r & ~((reg_wr && reg_addr == `ACS_OFF_IRQ_CLR) ? reg_wdata[2:0] : 3'h0))
                          | {trig_bad && state_r == ST_SAMPLE, go_conv, done_ev};
        end
    end
    assign irq = |(irq_stat_r & irq_en_r);

    // Read port: data one cycle after strobe
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rd_pend_r <= 1'b0;
            rd_addr_r <= 4'h0;
        end else begin
            rd_pend_r <= reg_rd;
            rd_addr_r <= reg_addr;
        end
    end

    always @* begin
        reg_rdata = 16'h0000;
        if (rd_pend_r) begin
            case (rd_addr_r)
                `ACS_OFF_CTRL1:    reg_rdata = ctrl_r & `ACS_CTRL1_WMASK;
                `ACS_OFF_RESULT:   reg_rdata = fmt(ctrl_r[`ACS_BIT_OUTPUT_FORMAT_HI:`ACS_BIT_OUTPUT_FORMAT_LO], mem_rdata);
                `ACS_OFF_IRQ_STAT: reg_rdata = {13'h0000, irq_stat_r};
                `ACS_OFF_IRQ_EN:   reg_rdata = {13'h0000, irq_en_r};
                `ACS_OFF_RES_IDX:  reg_rdata = {{(16-AW){1'b0}}, wr_idx_r};
                default:           reg_rdata = 16'h0000;
            endcase
        end
    end
endmodule

// *** sim/acs_core_model.sv ***
// Purpose: Behavioural SAR core answering conversion starts
// Assumes: Busy rises one cycle after the start pulse
// Notes:   Result lines wander once their hold time has run out
`timescale 1ns/1ps
module acs_core_model (
    // Clock and reset
    input  wire       sys_clk,
    input  wire       rst,
    // Core side
    input  wire       conv_start,
    output reg        conv_busy,
    output reg  [9:0] conv_result,
    // Bench control
    input  wire [9:0] res_val,
    input  wire       slow
);
    reg [5:0] cnt_r;
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            conv_busy   <= 1'b0;
            cnt_r       <= 6'h00;
            conv_result <= 10'h000;
        end else if (conv_start) begin
            conv_busy   <= 1'b1;
            cnt_r       <= slow ? 6'h2F : 6'h0B;
            conv_result <= res_val;
        end else if (cnt_r != 6'h00) begin
            cnt_r     <= cnt_r - 6'h01;
            conv_busy <= cnt_r > 6'h06;
        end else
            conv_result <= ~conv_result;
    end
endmodule

// *** sim/acs_seq_assertions.sv ***
// Purpose: Port checks of the sequencer
// Assumes: One clock, async active-high reset
// Notes:   Mirrors the last control write to know the mode
`timescale 1ns/1ps
module acs_seq_assertions (
    // Clock and reset
    input wire        sys_clk,
    input wire        rst,
    // Register port
    input wire [3:0]  reg_addr,
    input wire [15:0] reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [15:0] reg_rdata,
    // Trigger and core
    input wire        ext_int_pin,
    input wire        sh_sample,
    input wire        conv_start,
    input wire        conv_busy
);
    reg       on_r;
    reg       auto_r;
    reg [2:0] trig_r;
    wire      cwr = reg_wr && reg_addr == 4'h0;
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            on_r   <= 1'b0;
            auto_r <= 1'b0;
            trig_r <= 3'h0;
        end else if (cwr) begin
            on_r   <= reg_wdata[15];
            auto_r <= reg_wdata[2];
            trig_r <= reg_wdata[7:5];
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_off; cwr && !reg_wdata[15] |=> ##1 (!sh_sample && !conv_start); endproperty
    a_off: assert property (p_off) else $error("activity after turn off");
    property p_rsvtrig; on_r && (trig_r == 3'h3 || trig_r == 3'h5) |-> !conv_start; endproperty
    a_rsvtrig: assert property (p_rsvtrig) else $error("start on reserved trigger");
    property p_trig; on_r && trig_r == 3'h1 && sh_sample && $rose(ext_int_pin) |-> ##[2:6] conv_start; endproperty
    a_trig: assert property (p_trig) else $error("pin edge did not start");
    property p_start; conv_start |-> !sh_sample ##1 !conv_start; endproperty
    a_start: assert property (p_start) else $error("bad start pulse");
    property p_auto; on_r && auto_r && $fell(conv_busy) |-> ##[1:8] sh_sample; endproperty
    a_auto: assert property (p_auto) else $error("no auto restart");
    property p_samp; cwr && on_r && reg_wdata[15] && reg_wdata[1] && !reg_wdata[13] |-> ##[1:3] sh_sample; endproperty
    a_samp: assert property (p_samp) else $error("no sampling after write");
    property p_busy; reg_rd && reg_addr == 4'h0 && conv_busy && $past(conv_busy) |=> reg_rdata[1:0] == 2'b00; endproperty
    a_busy: assert property (p_busy) else $error("status bits wrong in conversion");
    property p_clr; reg_rd && reg_addr == 4'h5 && !on_r && !$past(on_r) |=> reg_rdata == 16'h0000; endproperty
    a_clr: assert property (p_clr) else $error("index kept while off");
    property p_rsv; reg_rd && reg_addr == 4'h0 |=> (reg_rdata & 16'h5C18) == 16'h0000; endproperty
    a_rsv: assert property (p_rsv) else $error("unused control bits set");
    c_conv: cover property (conv_start);
    c_auto: cover property (on_r && auto_r && $fell(conv_busy));
    c_trig: cover property (on_r && trig_r == 3'h1 && $rose(ext_int_pin));
endmodule
bind acs_seq acs_seq_assertions acs_seq_assertions_inst (
    .sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ext_int_pin, .sh_sample, .conv_start,
    .conv_busy);

// *** sim/tb_top.sv ***
// Purpose: Self-checking bench of the converter sequencer
// Assumes: Core model answers fast or slow on request
// Notes:   Random results from a fixed-seed xorshift
`timescale 1ns/1ps
module tb_top;
    reg         sys_clk;
    reg         rst;
    reg  [3:0]  reg_addr;
    reg  [15:0] reg_wdata;
    reg         reg_wr;
    reg         reg_rd;
    wire [15:0] reg_rdata;
    reg  [3:0]  trig;
    reg         cpu_idle;
    wire        sh_sample;
    wire        conv_start;
    wire        conv_busy;
    wire [9:0]  conv_result;
    wire        irq;
    reg  [9:0]  res_val;
    reg         slow;
    reg  [31:0] seed;
    reg  [15:0] d;
    reg  [15:0] ctl;
    reg  [2:0]  code;
    reg  [1:0]  f;
    integer     errors, n_compared, i, k;
    wire [31:0] smap = 32'h04020180 >> {code, 2'b00};
    acs_seq acs_seq_inst (
        .sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .trig_charge(trig[2]),
        .trig_timer_a(trig[0]), .trig_timer_b(trig[1]), .ext_int_pin(trig[3]), .cpu_idle, .sh_sample,
        .conv_start, .conv_busy, .conv_result, .irq);
    acs_core_model acs_core_model_inst (.sys_clk, .rst, .conv_start, .conv_busy, .conv_result, .res_val, .slow);
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    function [15:0] fmt_exp(input [1:0] fm, input [9:0] v);
        fmt_exp = fm[1] ? {v[9] ^ fm[0], v[8:0], 6'h00} : (fm[0] ? {{7{~v[9]}}, v[8:0]} : {6'h00, v});
    endfunction
    task wr(input [3:0] a, input [15:0] v);
        begin
            @(posedge sys_clk);
            reg_wr    <= 1'b1;
            reg_addr  <= a;
            reg_wdata <= v;
            @(posedge sys_clk);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [3:0] a, output [15:0] v);
        begin
            @(posedge sys_clk);
            reg_rd   <= 1'b1;
            reg_addr <= a;
            @(posedge sys_clk);
            reg_rd <= 1'b0;
            #1 v = reg_rdata;
        end
    endtask
    task chk(input [8*12:1] nm, input [15:0] e, input [15:0] g);
        begin
            n_compared = n_compared + 1;
            if (g !== e) begin
                errors = errors + 1;
                $display("MISMATCH %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task tally_and_finish;
        begin
            $display("compared %0d mismatches %0d", n_compared, errors);
            if (errors == 0 && n_compared > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        {rst, reg_addr, reg_wdata, reg_wr, reg_rd, trig, cpu_idle, res_val, slow} = {1'b1, 38'h0};
        {errors, n_compared, code} = 0;
        seed = 32'h0001503B;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rd(4'h0, d);
        chk("ctrl_reset", 16'h0000, d);
        rd(4'hF, d);
        chk("unmapped", 16'h0000, d);
        wr(4'h0, 16'h7F1C);
        rd(4'h0, d);
        chk("ctrl_mask", 16'h2304, d);
        for (i = 0; i < 6; i = i + 1) begin
            code = (i == 5) ? 3'h7 : (i < 2) ? i[2:0] : 3'((i - 1) * 2);
            f = i[1:0];
            seed = xs(seed);
            ctl = {1'b1, 5'h00, f, code, 2'b00, code == 3'h7, 2'b00};
            d = 16'h0000;
            res_val <= seed[9:0];
            slow <= (i == 3);
            cpu_idle <= (i == 2);
            wr(4'h0, ctl);
            wr(4'h0, ctl | 16'h0002);
            trig <= 4'hF & ~smap[3:0];
            repeat (6) @(posedge sys_clk);
            trig <= 4'h0;
            if (code != 3'h7) begin
                rd(4'h0, d);
                chk("sampling", 16'h0001, {15'h0000, d[1]});
            end
            if (code == 3'h0)
                wr(4'h0, ctl);
            else begin
                @(posedge sys_clk);
                trig <= smap[3:0];
            end
            for (k = 0; k < 100 && d[0] !== 1'b1; k = k + 1)
                rd(4'h0, d);
            chk("done", 16'h0001, {15'h0000, d[0]});
            if (d[0] !== 1'b1)
                tally_and_finish;
            if (code == 3'h7) begin
                rd(4'h0, d);
                chk("auto_restart", 16'h0001, {15'h0000, d[1]});
            end
            wr(4'h5, {12'h000, 4'(i)});
            rd(4'h1, d);
            chk("result", fmt_exp(f, res_val), d);
        end
        wr(4'h0, 16'h0000);
        wr(4'h5, 16'h0000);
        rd(4'h5, d);
        chk("index_clr", 16'h0000, d);
        rd(4'h1, d);
        chk("result_clr", 16'h0000, d);
        wr(4'h0, 16'h80A0);
        wr(4'h0, 16'h80A2);
        repeat (8) @(posedge sys_clk);
        #1 chk("irq_masked", 16'h0000, {15'h0000, irq});
        rd(4'h2, d);
        chk("stat_rsv", 16'h0004, d & 16'h0004);
        wr(4'h3, 16'h0004);
        @(posedge sys_clk);
        #1 chk("irq_on", 16'h0001, {15'h0000, irq});
        wr(4'h0, 16'h0000);
        wr(4'h4, 16'h0007);
        @(posedge sys_clk);
        #1 chk("irq_off", 16'h0000, {15'h0000, irq});
        cpu_idle <= 1'b1;
        wr(4'h0, 16'hA000);
        wr(4'h0, 16'hA002);
        repeat (3) @(posedge sys_clk);
        #1 chk("idle_halt", 16'h0000, {15'h0000, sh_sample});
        @(posedge sys_clk);
        cpu_idle <= 1'b0;
        wr(4'h0, 16'hA002);
        @(posedge sys_clk);
        #1 chk("idle_resume", 16'h0001, {15'h0000, sh_sample});
        tally_and_finish;
    end
endmodule
